// *** rtl/switch_irq_qos_pvid_regs.sv ***
// How it works
// - port 3 queue 0: strict or weighted select
// - 8-bit mask enables matching link flags
// - writing one clears a flag, zero keeps
// - bit 7 sets on port 1/2 copper change
// - bit 2 sets on port 3 link change
// - bit 1 sets on port 2 link change
// - bit 0 sets on any port 1 change
// - enabled limit waits 160 ms, then invalidates
// - bits 5,4 insert port 1 VID
// - bits 3,2 insert port 2 VID
module switch_irq_qos_pvid_regs
	import swregs_pkg::*;
#(
	parameter int unsigned PAUSE_CYC = 32'(swregs_pkg::PAUSE_WAIT_CYC)
) (
	input  wire logic                          clock,
	input  wire logic                          arst_n,
	input  wire logic [swregs_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [swregs_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [swregs_pkg::DATA_W-1:0] reg_rdata,
	output logic                               reg_rvalid,
	input  wire logic                          p1_copper_link,
	input  wire logic                          p2_copper_link,
	input  wire logic                          p1_mii_link,
	input  wire logic                          p3_mii_link,
	input  wire logic                          pause_active,
	output logic                               pause_invalidate_req,
	input  wire logic [3:0]                    egress_queue_ready,
	input  wire logic                          four_queue_mode,
	input  wire logic                          egress_queue_pop,
	output logic      [1:0]                    egress_queue_grant,
	output logic                               egress_queue_grant_valid,
	output logic                               regulator_disable,
	output logic                               ins_p1_vid_at_p2,
	output logic                               ins_p1_vid_at_p3,
	output logic                               ins_p2_vid_at_p1,
	output logic                               ins_p2_vid_at_p3,
	output logic                               irq_out_n
);
	import swregs_pkg::*;

	logic       rst_sync1_reg;
	logic       rst_n_reg;

	// reset released through two flops so every flop leaves reset together
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync1_reg <= 1'b0;
			rst_n_reg     <= 1'b0;
		end else begin
			rst_sync1_reg <= 1'b1;
			rst_n_reg     <= rst_sync1_reg;
		end
	end

	logic [7:0] sched_reg,  sched_next;
	logic [7:0] mask_reg,   mask_next;
	logic [7:0] flags_reg,  flags_next;
	logic [7:0] plim_reg,   plim_next;
	logic [7:0] ldo_reg,    ldo_next;
	logic [7:0] vid_reg,    vid_next;
	logic [7:0] rdata_reg,  rdata_next;
	logic       rvalid_reg, rvalid_next;
	logic [3:0] link_prev_reg, link_prev_next;
	logic [3:0] link_now;
	logic [3:0] link_transition;
	logic [7:0] flag_set;
	logic [7:0] flag_clr;

	// link edges: any change of a sampled link level is a transition
	assign link_now        = {p3_mii_link, p1_mii_link, p2_copper_link, p1_copper_link};
	assign link_transition = link_now ^ link_prev_reg;
	assign link_prev_next  = link_now;

	always_comb begin
		flag_set = 8'h00;
		flag_set[FLAG_P12_BIT] = link_transition[0] | link_transition[1];
		flag_set[FLAG_P3_BIT]  = link_transition[3];
		flag_set[FLAG_P2_BIT]  = link_transition[1];
		flag_set[FLAG_P1_BIT]  = link_transition[0] | link_transition[2];
	end

	// write-one-to-clear; a transition in the clear cycle keeps the flag
	assign flag_clr = (reg_wr && reg_addr == OFF_FLAGS) ? (reg_wdata & WMASK_FLAGS) : 8'h00;

	// register writes; read-only bits keep their reset value
	always_comb begin
		sched_next = sched_reg;
		mask_next  = mask_reg;
		plim_next  = plim_reg;
		ldo_next   = ldo_reg;
		vid_next   = vid_reg;
		flags_next = (flags_reg & ~flag_clr) | flag_set;
		if (reg_wr) begin
			case (reg_addr)
				OFF_SCHED: sched_next = (sched_reg & ~WMASK_SCHED) | (reg_wdata & WMASK_SCHED);
				OFF_IRQ_MASK: mask_next = reg_wdata;
				OFF_PAUSE_LIM: plim_next = reg_wdata;
				OFF_REGULATOR: ldo_next = (ldo_reg & ~WMASK_REGULATOR)
					| (reg_wdata & WMASK_REGULATOR);
				OFF_VID_INSERT: vid_next = (vid_reg & ~WMASK_VID_INSERT)
					| (reg_wdata & WMASK_VID_INSERT);
				default: ;
			endcase
		end
	end

	// read data one cycle after the strobe; unmapped offsets read zero
	always_comb begin
		rvalid_next = reg_rd;
		rdata_next  = rdata_reg;
		if (reg_rd) begin
			case (reg_addr)
				OFF_SCHED:      rdata_next = sched_reg;
				OFF_IRQ_MASK:   rdata_next = mask_reg;
				OFF_FLAGS:      rdata_next = flags_reg;
				OFF_PAUSE_LIM:  rdata_next = plim_reg;
				OFF_RSVD_C0:    rdata_next = RST_RSVD_C0;
				OFF_REGULATOR:  rdata_next = ldo_reg;
				OFF_VID_INSERT: rdata_next = vid_reg;
				default:        rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			sched_reg     <= RST_SCHED;
			mask_reg      <= RST_IRQ_MASK;
			flags_reg     <= RST_FLAGS;
			plim_reg      <= RST_PAUSE_LIM;
			ldo_reg       <= RST_REGULATOR;
			vid_reg       <= RST_VID_INSERT;
			rdata_reg     <= 8'h00;
			rvalid_reg    <= 1'b0;
			link_prev_reg <= 4'h0;
		end else begin
			sched_reg     <= sched_next;
			mask_reg      <= mask_next;
			flags_reg     <= flags_next;
			plim_reg      <= plim_next;
			ldo_reg       <= ldo_next;
			vid_reg       <= vid_next;
			rdata_reg     <= rdata_next;
			rvalid_reg    <= rvalid_next;
			link_prev_reg <= link_prev_next;
		end
	end

	// first sample after reset may flag a change if a link is already up;
	// software clears it once after setting the mask
	assign reg_rdata  = rdata_reg;
	assign reg_rvalid = rvalid_reg;

	// interrupt pin: low while any enabled flag stands
	logic irq_n_reg;
	logic irq_n_next;
	assign irq_n_next = ~|(mask_reg & flags_reg);
	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			irq_n_reg <= 1'b1;
		end else begin
			irq_n_reg <= irq_n_next;
		end
	end
	assign irq_out_n = irq_n_reg;

	// egress untagged-frame VID insertion selects
	assign ins_p1_vid_at_p2  = vid_reg[INS_P1_TO_P2_BIT];
	assign ins_p1_vid_at_p3  = vid_reg[INS_P1_TO_P3_BIT];
	assign ins_p2_vid_at_p1  = vid_reg[INS_P2_TO_P1_BIT];
	assign ins_p2_vid_at_p3  = vid_reg[INS_P2_TO_P3_BIT];
	assign regulator_disable = ldo_reg[LDO_DIS_BIT];

	// pause-off limit: any nonzero value enables it
	pause_off_timer #(
		.WAIT_CYC (PAUSE_CYC)
	) u_pause_off_timer (
		.clock          (clock),
		.rst_n          (rst_n_reg),
		.enable         (|plim_reg),
		.pause_active   (pause_active),
		.invalidate_req (pause_invalidate_req)
	);

	// queue arbiter: strict picks highest ready queue; weighted spends credits
	logic [3:0] credit_reg [4];
	logic [3:0] credit_next [4];
	logic [3:0] weight [4];
	logic [3:0] ready_m;
	logic [1:0] grant;
	logic       any_ready;
	logic       has_credit;

	assign ready_m   = four_queue_mode ? egress_queue_ready : {2'h0, egress_queue_ready[1:0]};
	assign any_ready = |ready_m;

	always_comb begin
		weight[3] = four_queue_mode ? W4_Q0 : 4'h0;
		weight[2] = four_queue_mode ? W4_Q1 : 4'h0;
		weight[1] = four_queue_mode ? W4_Q2 : W2_HI;
		weight[0] = four_queue_mode ? W4_Q3 : W2_LO;
	end

	// highest priority is queue 3; weighted mode skips queues with no credit
	always_comb begin
		grant      = 2'h0;
		has_credit = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (ready_m[i] && credit_reg[i] != 4'h0) begin
				grant      = 2'(i);
				has_credit = 1'b1;
			end
		end
		if (!sched_reg[SCHED_SEL_BIT] || !has_credit) begin
			for (int i = 0; i < 4; i++) begin
				if (ready_m[i]) begin
					grant = 2'(i);
				end
			end
		end
	end

	// credits reload to the ratio once every ready queue has spent its share
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			credit_next[i] = credit_reg[i];
		end
		if (sched_reg[SCHED_SEL_BIT] && any_ready && !has_credit) begin
			for (int i = 0; i < 4; i++) begin
				credit_next[i] = weight[i];
			end
		end else if (egress_queue_pop && any_ready && credit_reg[grant] != 4'h0) begin
			credit_next[grant] = credit_reg[grant] - 4'h1;
		end
	end

	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			for (int i = 0; i < 4; i++) begin
				credit_reg[i] <= 4'h0;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				credit_reg[i] <= credit_next[i];
			end
		end
	end

	assign egress_queue_grant       = grant;
	assign egress_queue_grant_valid = any_ready;
endmodule : switch_irq_qos_pvid_regs

// *** rtl/swregs_pkg.sv ***
package swregs_pkg;
	localparam int          ADDR_W           = 8;
	localparam int          DATA_W           = 8;
	localparam int          FLAG_W           = 8;
	// register offsets
	localparam logic [7:0]  OFF_SCHED        = 8'hBA;
	localparam logic [7:0]  OFF_IRQ_MASK     = 8'hBB;
	localparam logic [7:0]  OFF_FLAGS        = 8'hBC;
	localparam logic [7:0]  OFF_PAUSE_LIM    = 8'hBD;
	localparam logic [7:0]  OFF_RSVD_C0      = 8'hC0;
	localparam logic [7:0]  OFF_REGULATOR    = 8'hC1;
	localparam logic [7:0]  OFF_VID_INSERT   = 8'hC2;
	// field positions
	localparam int          SCHED_SEL_BIT    = 7;
	localparam int          FLAG_P12_BIT     = 7;
	localparam int          FLAG_P3_BIT      = 2;
	localparam int          FLAG_P2_BIT      = 1;
	localparam int          FLAG_P1_BIT      = 0;
	localparam int          LDO_DIS_BIT      = 6;
	localparam int          INS_P1_TO_P2_BIT = 5;
	localparam int          INS_P1_TO_P3_BIT = 4;
	localparam int          INS_P2_TO_P1_BIT = 3;
	localparam int          INS_P2_TO_P3_BIT = 2;
	// reset values
	localparam logic [7:0]  RST_SCHED        = 8'h81;
	localparam logic [7:0]  RST_IRQ_MASK     = 8'h00;
	localparam logic [7:0]  RST_FLAGS        = 8'h00;
	localparam logic [7:0]  RST_PAUSE_LIM    = 8'h00;
	localparam logic [7:0]  RST_RSVD_C0      = 8'h03;
	localparam logic [7:0]  RST_REGULATOR    = 8'h00;
	localparam logic [7:0]  RST_VID_INSERT   = 8'h00;
	// writable masks; other bits keep their reset value
	localparam logic [7:0]  WMASK_SCHED      = 8'h80;
	localparam logic [7:0]  WMASK_REGULATOR  = 8'h40;
	localparam logic [7:0]  WMASK_VID_INSERT = 8'h3C;
	localparam logic [7:0]  WMASK_FLAGS      = 8'h87;
	// weighted ratios of the queue scheduler
	localparam logic [3:0]  W4_Q0            = 4'h8;
	localparam logic [3:0]  W4_Q1            = 4'h4;
	localparam logic [3:0]  W4_Q2            = 4'h2;
	localparam logic [3:0]  W4_Q3            = 4'h1;
	localparam logic [3:0]  W2_HI            = 4'h2;
	localparam logic [3:0]  W2_LO            = 4'h1;
	// pause-off wait, 160 ms at 250 MHz
	localparam longint      PAUSE_WAIT_MS    = 160;
	localparam longint      CLK_MHZ          = 250;
	localparam longint      PAUSE_WAIT_CYC   = PAUSE_WAIT_MS * 1000 * CLK_MHZ;
endpackage : swregs_pkg

// *** rtl/pause_off_timer.sv ***
// counts a pause episode and asks once to drop flow control after the wait
module pause_off_timer #(
	parameter int unsigned WAIT_CYC = 40000000
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic enable,
	input  wire logic pause_active,
	output logic      invalidate_req
);
	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic        fired_reg;
	logic        fired_next;
	logic        req_reg;
	logic        req_next;

	// counter restarts with every new pause episode; fires once per episode
	always_comb begin
		count_next = count_reg;
		fired_next = fired_reg;
		req_next   = 1'b0;
		if (!enable || !pause_active) begin
			count_next = 32'h0;
			fired_next = 1'b0;
		end else if (!fired_reg) begin
			if (count_reg >= WAIT_CYC - 1) begin
				req_next   = 1'b1;
				fired_next = 1'b1;
			end else begin
				count_next = count_reg + 32'h1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= 32'h0;
			fired_reg <= 1'b0;
			req_reg   <= 1'b0;
		end else begin
			count_reg <= count_next;
			fired_reg <= fired_next;
			req_reg   <= req_next;
		end
	end

	assign invalidate_req = req_reg;
endmodule : pause_off_timer

// *** tb/swregs_assertions.sv ***
module swregs_assertions
	import swregs_pkg::*;
#(
	parameter int unsigned PAUSE_CYC = 20
) (
	input wire logic       clock,
	input wire logic       arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       p1_copper_link,
	input wire logic       p2_copper_link,
	input wire logic       p1_mii_link,
	input wire logic       p3_mii_link,
	input wire logic       pause_active,
	input wire logic       pause_invalidate_req,
	input wire logic [3:0] egress_queue_ready,
	input wire logic       four_queue_mode,
	input wire logic [1:0] egress_queue_grant,
	input wire logic       ins_p1_vid_at_p2,
	input wire logic       ins_p1_vid_at_p3,
	input wire logic       ins_p2_vid_at_p1,
	input wire logic       ins_p2_vid_at_p3,
	input wire logic       irq_out_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  sel_reg, mask_reg, lim_reg, vid_reg;
	int unsigned run_reg;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// shadows of host writes, so checks follow what software asked for
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sel_reg <= RST_SCHED;
			mask_reg <= RST_IRQ_MASK;
			lim_reg <= RST_PAUSE_LIM;
			vid_reg <= RST_VID_INSERT;
			run_reg <= 0;
		end else begin
			run_reg <= pause_active ? run_reg + 1 : 0;
			if (reg_wr && reg_addr == OFF_SCHED) sel_reg <= reg_wdata;
			if (reg_wr && reg_addr == OFF_IRQ_MASK) mask_reg <= reg_wdata;
			if (reg_wr && reg_addr == OFF_PAUSE_LIM) lim_reg <= reg_wdata;
			if (reg_wr && reg_addr == OFF_VID_INSERT) vid_reg <= reg_wdata;
		end
	end
	strict_grant_a : assert property (
		!sel_reg[SCHED_SEL_BIT] && four_queue_mode && |egress_queue_ready |->
		egress_queue_grant == (egress_queue_ready[3] ? 2'h3 : egress_queue_ready[2] ? 2'h2 :
		egress_queue_ready[1] ? 2'h1 : 2'h0)) else $error("strict pick wrong");
	copper_flag_a : assert property (
		($changed(p1_copper_link) || $changed(p2_copper_link)) && mask_reg[7] |->
		##[1:3] !irq_out_n) else $error("copper change no irq");
	p3_flag_a : assert property (
		$changed(p3_mii_link) && mask_reg[2] |-> ##[1:3] !irq_out_n) else $error("p3 no irq");
	p2_flag_a : assert property (
		$changed(p2_copper_link) && mask_reg[1] |-> ##[1:3] !irq_out_n) else $error("p2 no irq");
	p1_flag_a : assert property (
		($changed(p1_copper_link) || $changed(p1_mii_link)) && mask_reg[0] |->
		##[1:3] !irq_out_n) else $error("p1 no irq");
	masked_quiet_a : assert property (
		(mask_reg == 8'h00) [*3] |-> irq_out_n) else $error("irq while fully masked");
	pause_off_a : assert property (
		lim_reg == 8'h00 && $past(lim_reg) == 8'h00 |-> !pause_invalidate_req)
		else $error("pause request while disabled");
	pause_wait_a : assert property (
		pause_invalidate_req |-> run_reg >= PAUSE_CYC ##1 !pause_invalidate_req)
		else $error("pause request early or long");
	ins_p1_a : assert property (
		{ins_p1_vid_at_p2, ins_p1_vid_at_p3} == vid_reg[5:4]) else $error("p1 insert bits");
	ins_p2_a : assert property (
		{ins_p2_vid_at_p1, ins_p2_vid_at_p3} == vid_reg[3:2]) else $error("p2 insert bits");
endmodule : swregs_assertions

bind switch_irq_qos_pvid_regs swregs_assertions #(.PAUSE_CYC(PAUSE_CYC)) swregs_assertions_inst (
	.clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .p1_copper_link, .p2_copper_link,
	.p1_mii_link, .p3_mii_link, .pause_active, .pause_invalidate_req, .egress_queue_ready,
	.four_queue_mode, .egress_queue_grant, .ins_p1_vid_at_p2, .ins_p1_vid_at_p3,
	.ins_p2_vid_at_p1, .ins_p2_vid_at_p3, .irq_out_n);

// *** tb/switch_irq_qos_pvid_regs_test.sv ***
module switch_irq_qos_pvid_regs_test import swregs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PCYC = 20;
	logic       clock = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic       pause_active = 1'b0, four_queue_mode = 1'b1, egress_queue_pop = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
	logic [3:0] links = 4'h0;  // p3 mii, p1 mii, p2 copper, p1 copper
	logic [3:0] ready = 4'h0, ins;
	logic [1:0] grant;
	logic       rvalid, gvalid, preq, ldo, irq_n;
	int         error_cnt = 0, samples_checked = 0, seed = 68504, n, cnt [4];
	logic [7:0] adr [8] = '{OFF_SCHED, OFF_IRQ_MASK, OFF_FLAGS, OFF_PAUSE_LIM, OFF_RSVD_C0,
		OFF_REGULATOR, OFF_VID_INSERT, 8'hC5};
	logic [7:0] mdl [8] = '{RST_SCHED, RST_IRQ_MASK, RST_FLAGS, RST_PAUSE_LIM, RST_RSVD_C0,
		RST_REGULATOR, RST_VID_INSERT, 8'h00};
	logic [7:0] wm [8] = '{WMASK_SCHED, 8'hFF, 8'h00, 8'hFF, 8'h00, WMASK_REGULATOR,
		WMASK_VID_INSERT, 8'h00};
	logic [7:0] pat [4] = '{8'h81, 8'h82, 8'h01, 8'h04};
	always #2 clock = ~clock;
	switch_irq_qos_pvid_regs #(.PAUSE_CYC(PCYC)) switch_irq_qos_pvid_regs_inst (
		.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(rvalid),
		.p1_copper_link(links[0]), .p2_copper_link(links[1]), .p1_mii_link(links[2]),
		.p3_mii_link(links[3]), .pause_active(pause_active), .pause_invalidate_req(preq),
		.egress_queue_ready(ready), .four_queue_mode(four_queue_mode),
		.egress_queue_pop(egress_queue_pop), .egress_queue_grant(grant),
		.egress_queue_grant_valid(gvalid), .regulator_disable(ldo),
		.ins_p1_vid_at_p2(ins[3]), .ins_p1_vid_at_p3(ins[2]), .ins_p2_vid_at_p1(ins[1]),
		.ins_p2_vid_at_p3(ins[0]), .irq_out_n(irq_n));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	// bus tasks start and end on a rising edge; strobes get a free edge between uses
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(posedge clock);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		check({7'h0, rvalid}, 8'h01);
		check(reg_rdata, e);
		@(posedge clock);
	endtask : rd
	task automatic close_out;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out
	initial begin
		repeat (6) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		check({7'h0, irq_n}, 8'h01);
		// reset values, then random writes; read-only bits keep their value, 0xC5 unmapped
		for (int i = 0; i < 8; i++) rd(adr[i], mdl[i]);
		for (int i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			mdl[i] = (mdl[i] & ~wm[i]) | (d & wm[i]);
			wr(adr[i], d);
			rd(adr[i], mdl[i]);
		end
		check({4'h0, ins}, {4'h0, mdl[6][5:2]});
		check({7'h0, ldo}, {7'h0, mdl[5][LDO_DIS_BIT]});
		// one link at a time; the mask alternately misses and covers the flag
		for (int i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			d = i[0] ? (d | pat[i]) : (d & ~pat[i]);
			wr(OFF_IRQ_MASK, d);
			wr(OFF_FLAGS, 8'hFF);
			links[i] <= ~links[i];
			repeat (3) @(posedge clock);
			rd(OFF_FLAGS, pat[i]);
			check({7'h0, irq_n}, {7'h0, (d & pat[i]) == 8'h00});
		end
		// every link changes, then a random subset is cleared; bit 7 survives
		wr(OFF_IRQ_MASK, 8'hFF);
		links <= ~links;
		repeat (3) @(posedge clock);
		d = 8'($random(seed)) & 8'h7F;
		wr(OFF_FLAGS, d);
		rd(OFF_FLAGS, 8'h87 & ~d);
		check({7'h0, irq_n}, 8'h00);
		wr(OFF_IRQ_MASK, 8'h00);
		repeat (2) @(posedge clock);
		check({7'h0, irq_n}, 8'h01);
		// enabled limit: one request per long episode, none once disabled
		wr(OFF_PAUSE_LIM, 8'h01);
		pause_active <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (preq !== 1'b1 && n < 100);
		check(8'(n == PCYC), 8'h01);
		if (n >= 100) close_out();
		n = 0;
		repeat (30) begin
			@(posedge clock);
			#1;
			n += int'(preq !== 1'b0);
		end
		check(8'(n), 8'h00);
		@(posedge clock);
		pause_active <= 1'b0;
		wr(OFF_PAUSE_LIM, 8'h00);
		pause_active <= 1'b1;
		n = 0;
		repeat (40) begin
			@(posedge clock);
			#1;
			n += int'(preq !== 1'b0);
		end
		check(8'(n), 8'h00);
		// strict pick over random ready sets in both queue modes
		@(posedge clock);
		pause_active <= 1'b0;
		wr(OFF_SCHED, 8'h00);
		for (int i = 0; i < 20; i++) begin
			d = 8'($random(seed));
			ready <= d[3:0];
			four_queue_mode <= d[4];
			@(posedge clock);
			#1;
			d = d[4] ? {4'h0, d[3:0]} : {6'h0, d[1:0]};
			check({7'h0, gvalid}, {7'h0, |d});
			if (|d) check({6'h0, grant}, d[3] ? 8'h3 : d[2] ? 8'h2 : d[1] ? 8'h1 : 8'h0);
			@(posedge clock);
		end
		// weighted shares: 8:4:2:1 over 15 pops, then 2:1 over 3
		for (int m = 1; m >= 0; m--) begin
			// nothing ready while the select flips, so credits reload only in the new mode
			ready <= 4'h0;
			wr(OFF_SCHED, 8'h80);
			four_queue_mode <= m[0];
			ready <= m[0] ? 4'hF : 4'h3;
			repeat (2) @(posedge clock);
			cnt = '{0, 0, 0, 0};
			egress_queue_pop <= 1'b1;
			repeat (m[0] ? 15 : 3) begin
				#1;
				cnt[grant]++;
				@(posedge clock);
			end
			egress_queue_pop <= 1'b0;
			for (int q = 0; q < 4; q++) begin
				n = m[0] ? 1 << q : (q < 2 ? q + 1 : 0);
				check(8'(cnt[q]), 8'(n));
			end
		end
		close_out();
	end
endmodule : switch_irq_qos_pvid_regs_test
